//--- hw/i2c_wake_pkg.sv
// Constants and types for the wake-on-data two-wire serial target
package i2c_wake_pkg;
    localparam int unsigned REF_CLK_HZ = 125_000_000;
    localparam int unsigned TIMEOUT_MS = 15;
    localparam int unsigned TIMEOUT_CYC = REF_CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int unsigned NVM_STORE_MS = 25;
    localparam int unsigned MAX_BUS_KBPS = 100;
    localparam int TMR_W = 21;
    localparam logic [TMR_W-1:0] TMR_ZERO = 21'h00000;
    localparam logic [TMR_W-1:0] TMR_ONE = 21'h00001;
    localparam logic [6:0] OWN_ADDR_DEF = 7'h68;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Link side states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RECV = 7'h02,
        ST_RX_STALL = 7'h04,
        ST_ACK = 7'h08,
        ST_TX_STALL = 7'h10,
        ST_SEND = 7'h20,
        ST_MACK = 7'h40
    } link_state_t;
    // Toggle events from the link to the reference domain
    typedef struct packed {
        logic rx_req;
        logic tx_req;
        logic byte_evt;
        logic done;
    } link_evt_t;
    // One buffer slot
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_slot_t;
endpackage

//--- hw/i2c_wake_target.sv
// Two-wire serial target with wake on data edge and sleep timer
`timescale 1ns/10ps
module i2c_wake_target
    import i2c_wake_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF
)
(
    input wire logic i_ref_clk,        // System clock, 125 MHz
    input wire logic i_rst,            // Async reset, active high
    input wire logic i_link_clk,       // Pin sampling clock
    input wire logic i_scl,            // Serial clock pin level
    input wire logic i_sda,            // Serial data pin level
    output logic o_scl_out,            // Clock drive value, always low
    output logic o_scl_oe,             // Clock pulled low when high
    output logic o_sda_out,            // Data drive value, always low
    output logic o_sda_oe,             // Data pulled low when high
    output logic o_rx_valid,           // Received byte available
    output logic [7:0] o_rx_data,      // Received byte
    input wire logic i_rx_ready,       // Consumer takes byte
    input wire logic i_tx_valid,       // Byte to send offered
    input wire logic [7:0] i_tx_data,  // Byte to send
    output logic o_tx_ready,           // Target asks for a send byte
    output logic o_awake               // Interface awake
);
    // Link domain state
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_p;
    logic sda_p;
    logic [1:0] awake_sync;
    logic [1:0] rx_ack_sync;
    logic [1:0] tx_ack_sync;
    link_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg;
    logic is_addr, next_is_addr;
    logic rw, next_rw;
    logic data_seen, next_data_seen;
    logic scl_oe, next_scl_oe;
    logic sda_oe, next_sda_oe;
    link_evt_t evt, next_evt;
    logic scl_h, sda_h, rise, fall, start, stop;
    // Reference domain state
    link_evt_t evt_s1, evt_s2, seen, next_seen, pend;
    logic [1:0] sda_r;
    logic sda_rp;
    logic awake, next_awake;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic [7:0] tx_hold, next_tx_hold;
    logic tx_ready, next_tx_ready;
    byte_slot_t head, next_head, tail, next_tail;
    logic push, pop, take, fall_r;

    // Pin and crossing synchronisers on the link clock
    // Oversampling far above bus rate
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            awake_sync <= 2'h0;
            rx_ack_sync <= 2'h0;
            tx_ack_sync <= 2'h0;
        end
        else
        begin
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
            scl_p <= scl_sync[1];
            sda_p <= sda_sync[1];
            awake_sync <= {awake_sync[0], awake};
            rx_ack_sync <= {rx_ack_sync[0], seen.rx_req};
            tx_ack_sync <= {tx_ack_sync[0], seen.tx_req};
        end
    end

    // Bus conditions from synchronised levels
    assign scl_h = scl_sync[1];
    assign sda_h = sda_sync[1];
    assign rise = scl_h & ~scl_p;
    assign fall = ~scl_h & scl_p;
    // Start detect, only when already awake
    assign start = awake_sync[1] & scl_h & scl_p & sda_p & ~sda_h;
    assign stop = scl_h & scl_p & ~sda_p & sda_h;

    // Link state machine next values
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_is_addr = is_addr;
        next_rw = rw;
        next_data_seen = data_seen;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_evt = evt;
        if (stop)
        begin
            next_state = ST_IDLE;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_data_seen = 1'b0;
            if (data_seen)
                next_evt.done = ~evt.done;
        end
        else if (start)
        begin
            // Start or repeated start restarts addressing
            next_state = ST_RECV;
            next_cnt = CNT_ZERO;
            next_is_addr = 1'b1;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    // Never drives the bus when idle
                    next_scl_oe = 1'b0;
                    next_sda_oe = 1'b0;
                end
                ST_RECV:
                begin
                    if (rise && cnt != BYTE_BITS)
                    begin
                        next_shreg = {shreg[6:0], sda_h};
                        next_cnt = cnt + CNT_ONE;
                    end
                    else if (fall && cnt == BYTE_BITS)
                    begin
                        next_evt.byte_evt = ~evt.byte_evt;
                        if (is_addr)
                        begin
                            if (shreg[7:1] == OWN_ADDR)
                            begin
                                next_rw = shreg[0];
                                next_state = ST_ACK;
                                next_sda_oe = 1'b1;
                            end
                            else
                            begin
                                next_state = ST_IDLE;
                            end
                        end
                        else
                        begin
                            next_state = ST_RX_STALL;
                            next_scl_oe = 1'b1;
                            next_evt.rx_req = ~evt.rx_req;
                            next_data_seen = 1'b1;
                        end
                    end
                end
                ST_RX_STALL:
                begin
                    if (rx_ack_sync[1] == evt.rx_req)
                    begin
                        // Acknowledge set while clock held low
                        next_state = ST_ACK;
                        next_sda_oe = 1'b1;
                    end
                end
                ST_ACK:
                begin
                    // Clock let go one edge after the data
                    next_scl_oe = 1'b0;
                    if (fall)
                    begin
                        next_sda_oe = 1'b0;
                        next_is_addr = 1'b0;
                        next_cnt = CNT_ZERO;
                        if (rw)
                        begin
                            next_state = ST_TX_STALL;
                            next_scl_oe = 1'b1;
                            next_evt.tx_req = ~evt.tx_req;
                        end
                        else
                            next_state = ST_RECV;
                    end
                end
                ST_TX_STALL:
                begin
                    if (tx_ack_sync[1] == evt.tx_req)
                    begin
                        // First bit set while clock low
                        next_shreg = tx_hold;
                        next_sda_oe = ~tx_hold[7];
                        next_cnt = CNT_ZERO;
                        next_data_seen = 1'b1;
                        next_state = ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    // Clock let go after the first bit stands
                    next_scl_oe = 1'b0;
                    if (rise)
                        next_cnt = cnt + CNT_ONE;
                    else if (fall)
                    begin
                        if (cnt == BYTE_BITS)
                        begin
                            next_sda_oe = 1'b0;
                            next_state = ST_MACK;
                        end
                        else
                        begin
                            // Next bit changes on clock low
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_oe = ~shreg[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (rise)
                    begin
                        next_evt.byte_evt = ~evt.byte_evt;
                        if (sda_h)
                            next_state = ST_IDLE;
                    end
                    else if (fall)
                    begin
                        next_state = ST_TX_STALL;
                        next_scl_oe = 1'b1;
                        next_evt.tx_req = ~evt.tx_req;
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                    next_scl_oe = 1'b0;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Link state machine registers
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= ST_IDLE;
            cnt <= CNT_ZERO;
            shreg <= BYTE_ZERO;
            is_addr <= 1'b0;
            rw <= 1'b0;
            data_seen <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            evt <= '0;
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            is_addr <= next_is_addr;
            rw <= next_rw;
            data_seen <= next_data_seen;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            evt <= next_evt;
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
        end
    end

    assign o_scl_oe = scl_oe;
    assign o_sda_oe = sda_oe;

    // Reference domain decode of pending events
    assign pend = link_evt_t'(evt_s2 ^ seen);
    assign fall_r = sda_rp & ~sda_r[1];
    assign push = pend.rx_req & ~tail.valid;
    assign pop = head.valid & i_rx_ready;
    assign take = tx_ready & i_tx_valid;

    // Handshakes, buffer, wake and timer next values
    always_comb
    begin
        next_seen = seen;
        next_seen.byte_evt = evt_s2.byte_evt;
        next_seen.done = evt_s2.done;
        next_tx_hold = tx_hold;
        next_tx_ready = pend.tx_req & ~take;
        next_head = head;
        next_tail = tail;
        next_awake = awake;
        next_tmr = tmr;
        if (push)
            next_seen.rx_req = ~seen.rx_req;
        if (take)
        begin
            next_tx_hold = i_tx_data;
            next_seen.tx_req = ~seen.tx_req;
        end
        // Two-entry buffer, full buffer withholds the link ack
        if (pop)
        begin
            if (tail.valid)
            begin
                next_head = tail;
                next_tail = '{valid: push, data: shreg};
            end
            else
                next_head = '{valid: push, data: shreg};
        end
        else if (!head.valid)
            next_head = '{valid: push, data: shreg};
        else if (push)
            next_tail = '{valid: 1'b1, data: shreg};
        if (fall_r)
        begin
            next_awake = 1'b1;
            next_tmr = TMR_W'(TIMEOUT_CYCLES);
        end
        else if (pend.done)
        begin
            // Sleep at once after a transfer
            next_awake = 1'b0;
            next_tmr = TMR_ZERO;
        end
        else if (pend.byte_evt)
        begin
            next_awake = 1'b1;
            next_tmr = TMR_W'(TIMEOUT_CYCLES);
        end
        else if (awake)
        begin
            // Expiry sends device back to sleep
            if (tmr <= TMR_ONE)
            begin
                next_awake = 1'b0;
                next_tmr = TMR_ZERO;
            end
            else
                next_tmr = tmr - TMR_ONE;
        end
    end

    // Reference domain registers
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            evt_s1 <= '0;
            evt_s2 <= '0;
            seen <= '0;
            sda_r <= 2'h3;
            sda_rp <= 1'b1;
            awake <= 1'b0;
            tmr <= TMR_ZERO;
            tx_hold <= BYTE_ZERO;
            tx_ready <= 1'b0;
            head <= '0;
            tail <= '0;
        end
        else
        begin
            evt_s1 <= evt;
            evt_s2 <= evt_s1;
            seen <= next_seen;
            sda_r <= {sda_r[0], i_sda};
            sda_rp <= sda_r[1];
            awake <= next_awake;
            tmr <= next_tmr;
            tx_hold <= next_tx_hold;
            tx_ready <= next_tx_ready;
            head <= next_head;
            tail <= next_tail;
        end
    end

    assign o_rx_valid = head.valid;
    assign o_rx_data = head.data;
    assign o_tx_ready = tx_ready;
    assign o_awake = awake;
endmodule // i2c_wake_target

//--- tb/i2c_wake_target_asserts.sv
// Port checks for the wake-on-data two-wire target
`timescale 1ns/10ps
module i2c_wake_target_asserts
    import i2c_wake_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input wire logic i_ref_clk,       // Clk
    input wire logic i_rst,           // Reset
    input wire logic i_link_clk,      // Link clk
    input wire logic i_scl,           // Clock wire
    input wire logic i_sda,           // Data wire
    input wire logic o_scl_out,       // Clock drive
    input wire logic o_scl_oe,        // Clock pull
    input wire logic o_sda_out,       // Data drive
    input wire logic o_sda_oe,        // Data pull
    input wire logic o_rx_valid,      // Rx valid
    input wire logic [7:0] o_rx_data, // Rx byte
    input wire logic i_rx_ready,      // Rx ready
    input wire logic i_tx_valid,      // Tx valid
    input wire logic [7:0] i_tx_data, // Tx byte
    input wire logic o_tx_ready,      // Tx ready
    input wire logic o_awake          // Awake
);
    logic [31:0] idle_cnt;
    logic [31:0] next_idle_cnt;
    logic sda_q;
    // Cycles spent awake with a quiet data line
    always_comb
    begin
        next_idle_cnt = (!o_awake || i_sda != sda_q) ? 32'h00000000 : idle_cnt + 32'h00000001;
    end
    // Register the counter and the last data level
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            idle_cnt <= 32'h00000000;
            sda_q <= 1'b1;
        end
        else
        begin
            idle_cnt <= next_idle_cnt;
            sda_q <= i_sda;
        end
    end
    drive_low_a:
        assert property (@(posedge i_link_clk) disable iff (i_rst) !o_sda_out && !o_scl_out)
        else $error("bus line driven high");
    sda_change_a:
        assert property (@(posedge i_link_clk) disable iff (i_rst) $changed(o_sda_oe) |-> !i_scl)
        else $error("data pull changed with clock high");
    // data settled before the stretch ends
    release_order_a:
        assert property (@(posedge i_link_clk) disable iff (i_rst)
            $fell(o_scl_oe) |-> $stable(o_sda_oe))
        else $error("data pull moved at clock release");
    stretch_low_a:
        assert property (@(posedge i_link_clk) disable iff (i_rst) $rose(o_scl_oe) |-> !i_scl)
        else $error("stretch began with clock high");
    quiet_sleep_a:
        assert property (@(posedge i_ref_clk) disable iff (i_rst)
            !o_awake |-> !o_sda_oe && !o_scl_oe)
        else $error("bus pulled while asleep");
    wake_fast_a:
        assert property (@(posedge i_ref_clk) disable iff (i_rst)
            $fell(i_sda) && !o_awake |-> ##[1:8] o_awake)
        else $error("no wake after data fall");
    idle_sleep_a:
        assert property (@(posedge i_ref_clk) disable iff (i_rst) idle_cnt <= TIMEOUT_CYCLES + 16)
        else $error("awake past inactivity limit");
    rx_hold_a:
        assert property (@(posedge i_ref_clk) disable iff (i_rst)
            o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
        else $error("stalled byte lost or changed");
    tx_take_a:
        assert property (@(posedge i_ref_clk) disable iff (i_rst)
            o_tx_ready && i_tx_valid |=> !o_tx_ready)
        else $error("send request held after take");
    stall_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        o_scl_oe && o_rx_valid && !i_rx_ready);
    take_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_tx_ready && i_tx_valid);
    sleep_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) $fell(o_awake));
endmodule // i2c_wake_target_asserts
bind i2c_wake_target i2c_wake_target_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (
    .i_ref_clk, .i_rst, .i_link_clk, .i_scl, .i_sda, .o_scl_out, .o_scl_oe, .o_sda_out,
    .o_sda_oe, .o_rx_valid, .o_rx_data, .i_rx_ready, .i_tx_valid, .i_tx_data, .o_tx_ready,
    .o_awake);

//--- tb/i2c_host_model.sv
// Behavioural bus controller driving clock and data open-drain
`timescale 1ns/10ps
module i2c_host_model
(
    input wire logic i_scl, // Clock wire
    input wire logic i_sda, // Data wire
    output logic o_scl_drv, // High releases
    output logic o_sda_drv  // High releases
);
    // standard mode, 10 us per bit, short start and stop phases
    localparam int HALF = 5000;
    localparam int QTR = 1250;
    initial
    begin
        o_scl_drv = 1'b1;
        o_sda_drv = 1'b1;
    end
    task automatic pulse(output logic smp);
        #(HALF - QTR) o_scl_drv = 1'b1;
        wait (i_scl === 1'b1);
        #(HALF / 2) smp = i_sda;
        #(HALF / 2) o_scl_drv = 1'b0;
    endtask
    task automatic start();
        #QTR o_sda_drv = 1'b1;
        #QTR o_scl_drv = 1'b1;
        wait (i_scl === 1'b1);
        #QTR o_sda_drv = 1'b0;
        #QTR o_scl_drv = 1'b0;
    endtask
    task automatic stop();
        #QTR o_sda_drv = 1'b0;
        #QTR o_scl_drv = 1'b1;
        wait (i_scl === 1'b1);
        #QTR o_sda_drv = 1'b1;
        #QTR;
    endtask
    // eight bits then the answer bit
    task automatic xfer(input logic [7:0] wb, input logic mack, output logic [7:0] rb,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            #QTR o_sda_drv = wb[i];
            pulse(s);
            rb[i] = s;
        end
        #QTR o_sda_drv = mack;
        pulse(s);
        ack = ~s;
    endtask
endmodule // i2c_host_model

//--- tb/i2c_wake_target_bench.sv
// Self-checking bench for the wake-on-data two-wire target
`timescale 1ns/10ps
module i2c_wake_target_bench
    import i2c_wake_pkg::*;
;
    localparam int TMO = 8000;
    logic i_ref_clk, i_link_clk, i_rst, i_rx_ready, i_tx_valid, scl_drv, sda_drv;
    logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_rx_valid, o_tx_ready, o_awake, ak, ak3;
    logic [7:0] i_tx_data, o_rx_data, rb;
    wire logic scl_w, sda_w;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    // Wired-AND with pull-ups
    assign scl_w = scl_drv & (o_scl_oe ? o_scl_out : 1'b1);
    assign sda_w = sda_drv & (o_sda_oe ? o_sda_out : 1'b1);
    i2c_wake_target #(.TIMEOUT_CYCLES(TMO)) dut (
        .i_ref_clk, .i_rst, .i_link_clk, .i_scl(scl_w), .i_sda(sda_w), .o_scl_out, .o_scl_oe,
        .o_sda_out, .o_sda_oe, .o_rx_valid, .o_rx_data, .i_rx_ready, .i_tx_valid, .i_tx_data,
        .o_tx_ready, .o_awake);
    i2c_host_model host (.i_scl(scl_w), .i_sda(sda_w), .o_scl_drv(scl_drv), .o_sda_drv(sda_drv));
    // Clocks, link clock off phase
    initial
    begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    initial
    begin
        i_link_clk = 1'b0;
        #3.1;
        forever #7.5 i_link_clk = ~i_link_clk;
    end
    // Hang guard, eight bytes and the idle wait take about 105000 cycles
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 115000)
        begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_val(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        while (s !== v && n < lim);
    endtask
    task automatic pop(input logic [7:0] exp);
        wait_val(o_rx_valid, 1'b1, 20000);
        chk(o_rx_data, exp);
        @(posedge i_ref_clk) i_rx_ready <= 1'b1;
        @(posedge i_ref_clk) i_rx_ready <= 1'b0;
    endtask
    // Wake with own address, left unanswered
    task automatic t_wake();
        host.start();
        host.xfer({OWN_ADDR_DEF, 1'b0}, 1'b1, rb, ak);
        chk(ak, 1'b0);
        host.stop();
        wait_val(o_awake, 1'b1, 1);
        chk(o_awake, 1'b1);
    endtask
    // Three bytes into a two-slot buffer with the consumer stalled
    task automatic t_write();
        host.start();
        host.xfer({OWN_ADDR_DEF, 1'b0}, 1'b1, rb, ak);
        chk(ak, 1'b1);
        host.xfer(8'hA5, 1'b1, rb, ak);
        chk(ak, 1'b1);
        host.xfer(8'h3C, 1'b1, rb, ak);
        chk(ak, 1'b1);
        fork
            host.xfer(8'h5A, 1'b1, rb, ak3);
            begin
                wait_val(o_scl_oe, 1'b1, 20000);
                repeat (200) @(posedge i_ref_clk);
                #1;
                chk(o_scl_oe, 1'b1);
                pop(8'hA5);
                pop(8'h3C);
                pop(8'h5A);
            end
        join
        chk(ak3, 1'b1);
        host.stop();
        wait_val(o_awake, 1'b0, 50);
        chk(o_awake, 1'b0);
    endtask
    // Foreign address, repeated start, one-byte read
    task automatic t_read();
        @(posedge i_ref_clk) i_tx_data <= 8'hA5;
        @(posedge i_ref_clk) i_tx_valid <= 1'b1;
        host.start();
        host.stop();
        host.start();
        host.xfer({7'h27, 1'b0}, 1'b1, rb, ak);
        chk(ak, 1'b0);
        host.start();
        host.xfer({OWN_ADDR_DEF, 1'b1}, 1'b1, rb, ak);
        chk(ak, 1'b1);
        host.xfer(8'hFF, 1'b1, rb, ak);
        chk(rb, 8'hA5);
        host.stop();
        wait_val(o_awake, 1'b0, 50);
        chk(o_awake, 1'b0);
        @(posedge i_ref_clk) i_tx_valid <= 1'b0;
    endtask
    // Wake then stay quiet until the timer runs out
    task automatic t_timeout();
        host.start();
        host.stop();
        repeat (TMO - 2000) @(posedge i_ref_clk);
        #1;
        chk(o_awake, 1'b1);
        repeat (2000) @(posedge i_ref_clk);
        #1;
        chk(o_awake, 1'b0);
    endtask
    initial
    begin
        i_rst = 1'b1;
        i_rx_ready = 1'b0;
        i_tx_valid = 1'b0;
        i_tx_data = 8'h00;
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        repeat (10) @(posedge i_ref_clk);
        t_wake();
        t_write();
        t_read();
        t_timeout();
        print_verdict();
    end
endmodule // i2c_wake_target_bench
